// ==== dtcc_defs.svh ====
`ifndef DTCC_DEFS_SVH
`define DTCC_DEFS_SVH
// register word addresses
`define DTCC_A_TVAL 8'h00
`define DTCC_A_TREL 8'h02
`define DTCC_A_TCTL 8'h04
`define DTCC_A_STAT 8'h06
`define DTCC_A_CLR 8'h07
`define DTCC_A_EN 8'h08
`define DTCC_A_CCV 8'h10
`define DTCC_A_CFG 8'h20
// timebase control fields
`define DTCC_TC_SEL_HI 2
`define DTCC_TC_RUN 3
`define DTCC_TC_STAG 4
`define DTCC_TC_W 5
// clock source codes 0..3 are prescaler taps
`define DTCC_CS_OVF 3'h4
`define DTCC_CS_CNT 3'h5
// channel config: bit 8 reads the single event done flag
`define DTCC_CFG_DONE 8
// reset values
`define DTCC_TCTL_RST 5'h00
`define DTCC_TREL_RST 16'h0000
// timing
`define DTCC_PRE_W 6
`define DTCC_STAG_CYC 8
`endif

// ==== dtcc_pkg.sv ====
package dtcc_pkg;
	// compare modes
	typedef enum logic [1:0] {
		DTCC_CMP_IRQ = 2'b00,
		DTCC_CMP_TGL = 2'b01,
		DTCC_CMP_IRQ1 = 2'b10,
		DTCC_CMP_SET = 2'b11
	} dtcc_cmp_t;
	// channel config, low byte of the config word
	typedef struct packed {
		logic one;
		logic dbl;
		dtcc_cmp_t mode;
		logic [1:0] edge_sel;
		logic func;
		logic tsel;
	} dtcc_cfg_t;
endpackage

// ==== dtcc_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtcc_timebase #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic tick_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wdata_in,
	input wire logic [W-1:0] reload_in,
	// status
	output logic [W-1:0] value_out,
	output logic ovf_out,
	output logic upd_out
);
	typedef struct packed {
		logic [W-1:0] val;
		logic ovf;
		logic upd;
	} dtcc_tb_st_t;
	dtcc_tb_st_t st, n;

	// count up; software write beats a tick in the same cycle
	always_comb begin
		n = st;
		n.ovf = 1'b0;
		n.upd = 1'b0;
		if (wr_in) begin
			n.val = wdata_in;
		end else if (tick_in) begin
			n.upd = 1'b1;
			if (&st.val) begin
				n.val = reload_in;
				n.ovf = 1'b1;
			end else begin
				n.val = st.val + W'(1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	assign value_out = st.val;
	assign ovf_out = st.ovf;
	assign upd_out = st.upd;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_TB_RELOAD:
	assert property (tick_in && !wr_in && (&st.val) |=>
		ovf_out && value_out == $past(reload_in))
	else $error("timebase did not reload on overflow");

	AST_TB_COUNT:
	assert property (tick_in && !wr_in && !(&st.val) |=>
		upd_out && !ovf_out && value_out == $past(value_out) + W'(1))
	else $error("timebase did not count up by one");
endmodule
`default_nettype wire

// ==== dtcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtcc_defs.svh"
module dtcc_top #(
	parameter int NCH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// channel pins
	input wire logic [NCH-1:0] pin_in,
	output logic [NCH-1:0] pin_out,
	output logic [NCH-1:0] pin_oe_n_out,
	// external count and overflow inputs
	input wire logic [1:0] cnt_in,
	input wire logic ext_ovf_in,
	// interrupt
	output logic irq_out
);
	localparam int HALF = NCH / 2;
	localparam int SW = $clog2(`DTCC_STAG_CYC);

	typedef struct packed {
		logic [15:0] rdata;
		logic [NCH-1:0] stat;
		logic [NCH-1:0] en;
		logic [NCH-1:0] done;
		logic [NCH-1:0] fired;
		logic [NCH-1:0] pin;
		logic [NCH-1:0] s1;
		logic [NCH-1:0] s2;
		logic [NCH-1:0] s3;
		logic [NCH-1:0][15:0] ccv;
		dtcc_pkg::dtcc_cfg_t [NCH-1:0] cfg;
		logic [1:0][`DTCC_TC_W-1:0] tctl;
		logic [1:0][15:0] trel;
		logic [1:0] c1;
		logic [1:0] c2;
		logic [1:0] c3;
		logic o1;
		logic o2;
		logic o3;
		logic [`DTCC_PRE_W-1:0] pre;
		logic [SW-1:0] stag;
	} dtcc_st_t;

	dtcc_st_t st, n;
	logic [1:0][15:0] tval;
	logic [1:0] tovf;
	logic [1:0] tupd;
	logic [1:0] tick;
	logic [1:0] twr;
	logic [NCH-1:0] cap_ev;
	logic [NCH-1:0] m;
	logic [NCH-1:0] sv;
	logic [NCH-1:0] clr;
	logic [15:0] cap_val8;

	// address block match on the upper nibble
	function automatic logic in_blk(input logic [7:0] a,
		input logic [7:0] base);
		in_blk = (a[7:4] == base[7:4]);
	endfunction

	// prescaler tap: divide by 1, 4, 16 or 64
	function automatic logic pre_hit(input logic [2:0] sel,
		input logic [`DTCC_PRE_W-1:0] p);
		case (sel)
			3'h0: pre_hit = 1'b1;
			3'h1: pre_hit = (p[1:0] == 2'h0);
			3'h2: pre_hit = (p[3:0] == 4'h0);
			3'h3: pre_hit = (p == 6'h00);
			default: pre_hit = 1'b0;
		endcase
	endfunction

	// two time bases
	generate
		for (genvar t = 0; t < 2; t++) begin : g_tb
			dtcc_timebase #(
				.W(16)
			) u_tb (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.tick_in(tick[t]),
				.wr_in(twr[t]),
				.wdata_in(wdata_in),
				.reload_in(st.trel[t]),
				.value_out(tval[t]),
				.ovf_out(tovf[t]),
				.upd_out(tupd[t])
			);
		end
	endgenerate

	// all next-state logic of the channel array and register file
	always_comb begin
		dtcc_pkg::dtcc_cfg_t c;
		logic [15:0] tv;
		logic [2:0] sel;
		logic src;
		logic rise;
		logic fall;
		logic [3:0] idx;
		c = '0;
		tv = '0;
		sel = '0;
		src = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		idx = addr_in[3:0];
		n = st;
		tick = '0;
		twr = '0;
		cap_ev = '0;
		m = '0;
		sv = '0;
		clr = '0;
		// pins and count inputs are asynchronous: two stages first
		n.s1 = pin_in;
		n.s2 = st.s1;
		n.s3 = st.s2;
		n.c1 = cnt_in;
		n.c2 = st.c1;
		n.c3 = st.c2;
		n.o1 = ext_ovf_in;
		n.o2 = st.o1;
		n.o3 = st.o2;
		n.pre = st.pre + `DTCC_PRE_W'(1);
		n.stag = st.stag + SW'(1);

		// timer clocking
		for (int t = 0; t < 2; t++) begin
			sel = st.tctl[t][`DTCC_TC_SEL_HI:0];
			if (sel == `DTCC_CS_OVF) begin
				src = st.o2 & ~st.o3;
			end else if (sel == `DTCC_CS_CNT) begin
				src = st.c2[t] & ~st.c3[t];
			end else begin
				src = pre_hit(sel, st.pre);
			end
			tick[t] = st.tctl[t][`DTCC_TC_RUN] & src &
				(~st.tctl[t][`DTCC_TC_STAG] |
				(st.stag == SW'(`DTCC_STAG_CYC - 1)));
			twr[t] = wr_in & (addr_in == `DTCC_A_TVAL + 8'(t));
		end

		// register writes
		if (wr_in) begin
			for (int t = 0; t < 2; t++) begin
				if (addr_in == `DTCC_A_TREL + 8'(t)) begin
					n.trel[t] = wdata_in;
				end
				if (addr_in == `DTCC_A_TCTL + 8'(t)) begin
					n.tctl[t] = wdata_in[`DTCC_TC_W-1:0];
				end
			end
			if (addr_in == `DTCC_A_EN) begin
				n.en = wdata_in[NCH-1:0];
			end
			if (addr_in == `DTCC_A_CLR) begin
				clr = wdata_in[NCH-1:0];
			end
			if (in_blk(addr_in, `DTCC_A_CCV)) begin
				n.ccv[idx] = wdata_in;
			end
			if (in_blk(addr_in, `DTCC_A_CFG)) begin
				n.cfg[idx] = dtcc_pkg::dtcc_cfg_t'(wdata_in[7:0]);
				n.done[idx] = 1'b0;
			end
		end

		// channel array; hardware updates win over software writes
		for (int i = 0; i < NCH; i++) begin
			c = st.cfg[i];
			tv = tval[c.tsel];
			if (!c.func) begin
				rise = st.s2[i] & ~st.s3[i];
				fall = ~st.s2[i] & st.s3[i];
				cap_ev[i] = (c.edge_sel[0] & rise) |
					(c.edge_sel[1] & fall);
				if (cap_ev[i]) begin
					n.ccv[i] = tv;
					sv[i] = 1'b1;
				end
			end else begin
				if (tovf[c.tsel]) begin
					n.fired[i] = 1'b0;
					if (c.mode == dtcc_pkg::DTCC_CMP_SET) begin
						n.pin[i] = 1'b0;
					end
				end
				m[i] = tupd[c.tsel] & (tv == st.ccv[i]) &
					~(c.one & st.done[i]);
				if (m[i]) begin
					if (c.one) begin
						n.done[i] = 1'b1;
					end
					if (i < HALF && c.dbl) begin
						sv[i] = 1'b1;
						n.pin[i] = ~n.pin[i];
					end else if (i >= HALF && st.cfg[i % HALF].dbl) begin
						sv[i] = 1'b1;
						n.pin[i % HALF] = ~n.pin[i % HALF];
					end else begin
						case (c.mode)
							dtcc_pkg::DTCC_CMP_IRQ: begin
								sv[i] = 1'b1;
							end
							dtcc_pkg::DTCC_CMP_TGL: begin
								sv[i] = 1'b1;
								n.pin[i] = ~st.pin[i];
							end
							dtcc_pkg::DTCC_CMP_IRQ1: begin
								if (!st.fired[i]) begin
									sv[i] = 1'b1;
									n.fired[i] = 1'b1;
								end
							end
							dtcc_pkg::DTCC_CMP_SET: begin
								if (!st.fired[i]) begin
									sv[i] = 1'b1;
									n.fired[i] = 1'b1;
									n.pin[i] = 1'b1;
								end
							end
							default: begin
								sv[i] = 1'b0;
							end
						endcase
					end
				end
			end
		end

		// sticky status: a new event beats a clear in the same cycle
		n.stat = (st.stat & ~clr) | sv;

		// read data stand in the cycle after the strobe only
		n.rdata = '0;
		if (rd_in) begin
			if (addr_in == `DTCC_A_STAT) begin
				n.rdata = 16'(st.stat);
			end else if (addr_in == `DTCC_A_EN) begin
				n.rdata = 16'(st.en);
			end else if (in_blk(addr_in, `DTCC_A_CCV)) begin
				n.rdata = st.ccv[idx];
			end else if (in_blk(addr_in, `DTCC_A_CFG)) begin
				n.rdata = 16'({st.done[idx], st.cfg[idx]});
			end
			for (int t = 0; t < 2; t++) begin
				if (addr_in == `DTCC_A_TVAL + 8'(t)) begin
					n.rdata = tval[t];
				end
				if (addr_in == `DTCC_A_TREL + 8'(t)) begin
					n.rdata = st.trel[t];
				end
				if (addr_in == `DTCC_A_TCTL + 8'(t)) begin
					n.rdata = 16'(st.tctl[t]);
				end
			end
		end
	end

	// single state register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.tctl <= {2{`DTCC_TCTL_RST}};
			st.trel <= {2{`DTCC_TREL_RST}};
		end else begin
			st <= n;
		end
	end

	// outputs
	assign rdata_out = st.rdata;
	assign pin_out = st.pin;
	// capture channels leave the pin undriven
	assign pin_oe_n_out = ~func_vec(st.cfg);
	assign irq_out = |(st.stat & st.en);
	// timer seen by the both-edge capture channel
	assign cap_val8 = tval[st.cfg[8].tsel];

	// compare function bit of every channel
	function automatic logic [NCH-1:0] func_vec(
		input dtcc_pkg::dtcc_cfg_t [NCH-1:0] cf);
		for (int i = 0; i < NCH; i++) begin
			func_vec[i] = cf[i].func;
		end
	endfunction

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_CAP_LOAD:
	assert property (cap_ev[8] |=> st.ccv[8] == $past(cap_val8))
	else $error("capture did not latch the timer value");

	AST_CAP_IRQ:
	assert property (cap_ev[8] |=> st.stat[8])
	else $error("capture did not set its status bit");

	AST_M0_PIN:
	assert property (st.cfg[0].func && !st.cfg[0].dbl &&
		st.cfg[0].mode == dtcc_pkg::DTCC_CMP_IRQ && m[0] |=>
		$stable(st.pin[0]) && st.stat[0])
	else $error("mode 0 match moved the pin or set no status");

	AST_M1_TGL:
	assert property (st.cfg[1].func && !st.cfg[1].dbl &&
		st.cfg[1].mode == dtcc_pkg::DTCC_CMP_TGL && m[1] |=>
		st.pin[1] != $past(st.pin[1]))
	else $error("mode 1 match did not toggle the pin");

	AST_M2_ONCE:
	assert property (st.cfg[2].func && st.fired[2] && !st.cfg[2].dbl &&
		st.cfg[2].mode == dtcc_pkg::DTCC_CMP_IRQ1 &&
		!tovf[st.cfg[2].tsel] |-> !sv[2])
	else $error("mode 2 raised a second request in one period");

	AST_M3_SET:
	assert property (st.cfg[3].func && !st.cfg[3].dbl &&
		st.cfg[3].mode == dtcc_pkg::DTCC_CMP_SET && m[3] &&
		!st.fired[3] |=> st.pin[3] && st.fired[3])
	else $error("mode 3 match did not set the pin");

	AST_M3_CLR:
	assert property (st.cfg[3].func && !st.cfg[3].dbl &&
		st.cfg[3].mode == dtcc_pkg::DTCC_CMP_SET &&
		tovf[st.cfg[3].tsel] && !m[3] |=> !st.pin[3])
	else $error("mode 3 pin not cleared on overflow");

	AST_DBL:
	assert property (st.cfg[5].func && st.cfg[5].dbl &&
		st.cfg[5].mode != dtcc_pkg::DTCC_CMP_SET &&
		(m[5] ^ m[HALF + 5]) |=> st.pin[5] != $past(st.pin[5]))
	else $error("double register match did not toggle the pin");

	AST_ONE:
	assert property (st.cfg[4].func && st.cfg[4].one && st.done[4] &&
		!st.cfg[4].dbl && st.cfg[4].mode == dtcc_pkg::DTCC_CMP_TGL
		|-> !sv[4] ##1 $stable(st.pin[4]))
	else $error("single event channel matched again");

	AST_STAG:
	assert property (tick[0] && st.tctl[0][`DTCC_TC_STAG] |->
		st.stag == SW'(`DTCC_STAG_CYC - 1))
	else $error("staggered timer ticked off its slot");
endmodule
`default_nettype wire

// ==== dtcc_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtcc_far_model #(
	parameter int NCH = 16
) (
	// clock
	input wire logic clk_in,
	// channel pins as the block sees them
	input wire logic [NCH-1:0] pin_out_in,
	input wire logic [NCH-1:0] pin_oe_n_in,
	output logic [NCH-1:0] pin_in_out,
	// count and overflow sources
	output logic [1:0] cnt_out,
	output logic ovf_out
);
	logic [NCH-1:0] drv_r;
	// pin wire level
	// a compare pin carries the block's level, a capture pin ours
	assign pin_in_out = (pin_oe_n_in & drv_r) | (~pin_oe_n_in & pin_out_in);
	// quiet sources at time zero
	initial begin
		drv_r = '0;
		cnt_out = 2'h0;
		ovf_out = 1'b0;
	end
	// external count edges
	// each level lasts four cycles so the synchroniser never misses it
	task automatic count(input int idx, input int n);
		repeat (n) begin
			@(posedge clk_in);
			cnt_out[idx] <= 1'b1;
			repeat (4) @(posedge clk_in);
			cnt_out[idx] <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
	endtask
	task automatic overflow();
		@(posedge clk_in);
		ovf_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		ovf_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	// new levels on the capture pins, then time for sync and capture
	task automatic set_pins(input logic [NCH-1:0] v);
		@(posedge clk_in);
		drv_r <= v;
		repeat (8) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== dtcc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtcc_defs.svh"
module dtcc_top_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata, pin_out, oe_n, pin_in, v, t0;
	logic [1:0] cnt;
	logic ovf, irq;
	int miscompares = 0;
	int checks = 0;
	// modes 0..3, single event toggle, double toggle
	logic [15:0] cfg [6] = '{16'h0002, 16'h0012, 16'h0022, 16'h0032,
		16'h0092, 16'h0052};
	// /1 /4 /16 /64 staggered, with ticks seen in 64 cycles
	logic [15:0] ctl [5] = '{16'h0008, 16'h0009, 16'h000a, 16'h000b,
		16'h0018};
	logic [15:0] inc [5] = '{16'h0040, 16'h0010, 16'h0004, 16'h0001,
		16'h0008};
	// 125 MHz clock
	always #4 clk = ~clk;
	dtcc_top #(.NCH(16)) u_dut (
		.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n_out(oe_n), .cnt_in(cnt),
		.ext_ovf_in(ovf), .irq_out(irq));
	dtcc_far_model #(.NCH(16)) u_far (
		.clk_in(clk), .pin_out_in(pin_out), .pin_oe_n_in(oe_n),
		.pin_in_out(pin_in), .cnt_out(cnt), .ovf_out(ovf));
	task automatic test_done();
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [15:0] e);
		logic [15:0] d;
		rreg(a, d);
		chk(nm, d, e);
	endtask
	// one count edge on timer 0, then settle past the match
	task automatic adv();
		u_far.count(0, 1);
		repeat (6) @(posedge clk);
		#1;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("tctl", `DTCC_A_TCTL, 16'h0000); // reset value
		rchk("trel", `DTCC_A_TREL, `DTCC_TREL_RST); // reset value
		rchk("stat", `DTCC_A_STAT, 16'h0000); // none pending
		chk("pin", pin_out, 16'h0000); // idle low
		chk("oe", oe_n, 16'hffff); // all inputs
		rchk("clr", `DTCC_A_CLR, 16'h0000); // write only
		rchk("hole", 8'hff, 16'h0000); // unmapped
		for (int i = 0; i < 6; i++) begin
			wreg(`DTCC_A_CCV + i[7:0], 16'hfffe);
			wreg(`DTCC_A_CFG + i[7:0], cfg[i]);
		end
		wreg(`DTCC_A_CCV + 8'h0d, 16'hffff);
		wreg(`DTCC_A_CFG + 8'h0d, 16'h0012);
		rchk("cfg13", `DTCC_A_CFG + 8'h0d, 16'h0012); // readback
		wreg(`DTCC_A_CFG + 8'h06, 16'h0004);
		wreg(`DTCC_A_CFG + 8'h07, 16'h0008);
		wreg(`DTCC_A_CFG + 8'h08, 16'h000d);
		wreg(`DTCC_A_EN, 16'hffff);
		wreg(`DTCC_A_TREL, 16'hfffd);
		wreg(`DTCC_A_TVAL, 16'hfffc);
		wreg(`DTCC_A_TCTL, 16'h000d);
		adv();
		chk("oe", oe_n, 16'hdfc0); // compare drives
		rchk("stat", `DTCC_A_STAT, 16'h0000); // no early match
		adv();
		rchk("stat", `DTCC_A_STAT, 16'h003f); // all modes match
		chk("pin", pin_out, 16'h003a); // set and toggle
		chk("irq", {15'h0000, irq}, 16'h0001); // request
		wreg(`DTCC_A_CLR, 16'hffff);
		rchk("stat", `DTCC_A_STAT, 16'h0000); // cleared
		chk("irq", {15'h0000, irq}, 16'h0000); // released
		adv();
		rchk("stat", `DTCC_A_STAT, 16'h2000); // upper register
		chk("pin", pin_out, 16'h001a); // lower pin toggles
		adv();
		rchk("tval", `DTCC_A_TVAL, 16'hfffd); // reload
		chk("pin", pin_out, 16'h0012); // overflow clears
		wreg(`DTCC_A_CLR, 16'hffff);
		adv();
		rchk("stat", `DTCC_A_STAT, 16'h002f); // single done
		chk("pin", pin_out, 16'h0038); // new period
		rchk("cfg4", `DTCC_A_CFG + 8'h04, 16'h0192); // done flag
		wreg(`DTCC_A_CLR, 16'hffff);
		wreg(`DTCC_A_TVAL, 16'hfffd);
		adv();
		rchk("stat", `DTCC_A_STAT, 16'h0023); // same period
		chk("pin", pin_out, 16'h001a); // once versus each
		// capture on both timers, interrupt masked then enabled
		wreg(`DTCC_A_CLR, 16'hffff);
		wreg(`DTCC_A_EN, 16'h0080);
		wreg(`DTCC_A_TVAL + 8'h01, 16'h1234);
		wreg(`DTCC_A_TCTL + 8'h01, 16'h000c);
		u_far.overflow();
		u_far.set_pins(16'h01c0);
		rchk("stat", `DTCC_A_STAT, 16'h0140); // rising edges
		chk("irq", {15'h0000, irq}, 16'h0000); // masked
		rchk("cap6", `DTCC_A_CCV + 8'h06, 16'hfffe); // timer 0
		rchk("cap8", `DTCC_A_CCV + 8'h08, 16'h1235); // timer 1
		wreg(`DTCC_A_CLR, 16'hffff);
		u_far.overflow();
		u_far.set_pins(16'h0000);
		rchk("stat", `DTCC_A_STAT, 16'h0180); // falling edges
		chk("irq", {15'h0000, irq}, 16'h0001); // enabled bit
		rchk("cap7", `DTCC_A_CCV + 8'h07, 16'hfffe); // falling copy
		rchk("cap8", `DTCC_A_CCV + 8'h08, 16'h1236); // both edges
		// tick rate over 64 cycles for each prescaler tap
		for (int i = 0; i < 5; i++) begin
			wreg(`DTCC_A_TCTL + 8'h01, ctl[i]);
			rreg(`DTCC_A_TVAL + 8'h01, t0);
			repeat (62) @(posedge clk);
			rreg(`DTCC_A_TVAL + 8'h01, v);
			chk("rate", v - t0, inc[i]); // resolution
		end
		test_done();
	end
endmodule
`default_nettype wire
